// [sim/bin_sorter_monitor.sv]
// Port checker for the bin sorter
`timescale 1ns/1ps
module bin_sorter_monitor
	import bin_sorter_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic reading_valid_in,
	input wire logic signed [data_w-1:0] reading_in,
	input wire logic over_range_in,
	input wire logic open_circuit_in,
	input wire logic over_upper_result_out,
	input wire logic under_lower_result_out,
	input wire logic [2:0] gear_pass_out,
	input wire logic sort_fail_out,
	input wire logic result_valid_out,
	input wire logic buzzer_out,
	input wire logic irq_out
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (sys_rst_in);
	wire logic [6:0] res = {over_upper_result_out, under_lower_result_out, gear_pass_out,
		sort_fail_out, buzzer_out};
	AST_NEG_UNDER: assert property (reading_valid_in && reading_in[31] && !over_range_in &&
		!open_circuit_in |-> ##2 result_valid_out && under_lower_result_out)
		else $error("negative reading not sorted under");
	AST_FLAG_OVER: assert property ((reading_valid_in && (over_range_in || open_circuit_in))
		|-> ##2 result_valid_out && over_upper_result_out) else $error("flag not sorted over");
	AST_ONE_CLASS: assert property (result_valid_out |-> $onehot(res[6:1]))
		else $error("result class not one-hot");
	AST_SINGLE_PULSE: assert property (result_valid_out |=> !result_valid_out)
		else $error("result pulse too long");
	AST_HOLD: assert property (!result_valid_out |-> $stable(res))
		else $error("result changed without pulse");
	AST_APB_READY: assert property (psel && !penable |=> pready) else $error("no ready");
	AST_READY_ACCESS: assert property (pready |-> psel && penable) else $error("stray ready");
	AST_ERR_READY: assert property (pslverr |-> pready) else $error("error without ready");
	AST_RESET_QUIET: assert property (disable iff (1'b0) sys_rst_in |=> !result_valid_out &&
		!irq_out && !buzzer_out && !pready) else $error("output active after reset");
endmodule
bind resistance_bin_sorter bin_sorter_monitor bin_sorter_monitor_inst (.clk_sys_in, .sys_rst_in,
	.psel, .penable, .pready, .pslverr, .reading_valid_in, .reading_in, .over_range_in,
	.open_circuit_in, .over_upper_result_out, .under_lower_result_out, .gear_pass_out,
	.sort_fail_out, .result_valid_out, .buzzer_out, .irq_out);

// [sim/meas_front_end.sv]
// Behavioural measurement front end feeding readings
`timescale 1ns/1ps
module meas_front_end (
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	input wire logic go_in,
	input wire logic signed [31:0] value_in,
	input wire logic [1:0] flags_in,
	output logic valid_out,
	output logic signed [31:0] reading_out,
	output logic over_range_out,
	output logic open_circuit_out
);
	// Outside a valid cycle the data is scrambled so no stale value looks good
	always_ff @(posedge clk_sys_in) begin
		valid_out <= go_in & ~sys_rst_in;
		if (go_in) begin
			reading_out <= value_in;
			{over_range_out, open_circuit_out} <= flags_in;
		end else begin
			reading_out <= ~reading_out;
			{over_range_out, open_circuit_out} <= ~{over_range_out, open_circuit_out};
		end
	end
endmodule

// [sim/testbench.sv]
// Self-checking bench for the bin sorter
`timescale 1ns/1ps
module testbench;
	import bin_sorter_pkg::*;
	typedef struct {logic [7:0] c; logic signed [31:0] r; logic [1:0] f; logic [5:0] e;} row_t;
	logic clk_sys_in = 0, sys_rst_in = 1, psel = 0, penable = 0, pwrite = 0, go = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, q;
	logic signed [31:0] val = 0;
	logic [1:0] flg = 0;
	logic pready, pslverr, rv, ovr, opn, ou, ul, sf, rvo, buz, irq, e;
	logic signed [31:0] rd;
	logic [2:0] gp;
	int miscompares = 0, cmp_count = 0, n_hi = 0, n_pass = 0, n_lo = 0;
	row_t rows [15] = '{'{8'h1b, 120, 0, 6'h02}, '{8'h1b, 180, 0, 6'h02},
		'{8'h1b, 250, 0, 6'h04}, '{8'h1b, 450, 0, 6'h08}, '{8'h1b, 350, 0, 6'h01},
		'{8'h1b, 600, 0, 6'h20}, '{8'h1b, 50, 0, 6'h10}, '{8'h1b, -5, 0, 6'h10},
		'{8'h1b, 150, 2, 6'h20}, '{8'h1b, 150, 1, 6'h20}, '{8'h2a, 450, 0, 6'h20},
		'{8'h2a, 350, 0, 6'h20}, '{8'h2a, 120, 0, 6'h02}, '{8'h2a, 90, 0, 6'h10},
		'{8'h29, 250, 0, 6'h20}};
	initial begin
		forever #12.5 clk_sys_in = ~clk_sys_in;
	end
	meas_front_end meas_front_end_inst (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
		.go_in(go), .value_in(val), .flags_in(flg), .valid_out(rv), .reading_out(rd),
		.over_range_out(ovr), .open_circuit_out(opn));
	resistance_bin_sorter resistance_bin_sorter_inst (.clk_sys_in(clk_sys_in),
		.sys_rst_in(sys_rst_in), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.reading_valid_in(rv), .reading_in(rd), .over_range_in(ovr), .open_circuit_in(opn),
		.over_upper_result_out(ou), .under_lower_result_out(ul), .gear_pass_out(gp),
		.sort_fail_out(sf), .result_valid_out(rvo), .buzzer_out(buz), .irq_out(irq));
	task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
		cmp_count++;
		if (g !== x) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", s, x, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge clk_sys_in);
		penable <= 1;
		do begin
			@(posedge clk_sys_in);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task automatic meas(input logic signed [31:0] v, input logic [1:0] f);
		int n;
		n = 0;
		@(posedge clk_sys_in);
		{go, val, flg} <= {1'b1, v, f};
		@(posedge clk_sys_in);
		go <= 0;
		do begin
			@(posedge clk_sys_in);
			n++;
		end while (rvo !== 1'b1 && n < 200);
		chk("result pulse", 1, rvo);
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#(25 * 20000);
		miscompares++;
		finish_test();
	end
	initial begin
		repeat (8) @(posedge clk_sys_in);
		sys_rst_in <= 0;
		apb(0, a_ctrl, 0);
		chk("ctrl reset", ctrl_rst, q);
		// Each upper limit kept above its lower limit
		apb(1, a_lo1, 100);
		apb(1, a_hi1, 200);
		apb(1, a_lo2, 150);
		apb(1, a_hi2, 300);
		apb(1, a_lo3, 400);
		apb(1, a_hi3, 500);
		foreach (rows[i]) begin
			apb(1, a_ctrl, {24'h0, rows[i].c});
			meas(rows[i].r, rows[i].f);
			chk("class", rows[i].e, {ou, ul, gp, sf});
			if (rows[i].e != 6'h01)
				chk("buzzer", (rows[i].c[5:4] == 1 && rows[i].e[3:1] != 0) ||
					(rows[i].c[5:4] == 2 && rows[i].e[5:4] != 0), buz);
			n_hi += rows[i].e[5];
			n_lo += rows[i].e[4];
			n_pass += (rows[i].e[3:1] != 0);
		end
		apb(0, a_cnt_hi, 0);
		chk("over count", n_hi, q);
		apb(0, a_cnt_pass, 0);
		chk("pass count", n_pass, q);
		apb(0, a_cnt_lo, 0);
		chk("under count", n_lo, q);
		apb(0, 8'h40, 0);
		chk("unmapped data", 0, q);
		chk("unmapped error", 1, e);
		apb(1, a_ctrl, 32'h69);
		apb(0, a_cnt_pass, 0);
		chk("count clear", 0, q);
		apb(1, a_irq_clr, 32'hf);
		apb(1, a_irq_en, 1);
		chk("irq idle", 0, irq);
		meas(120, 0);
		repeat (2) @(posedge clk_sys_in);
		chk("irq set", 1, irq);
		apb(1, a_irq_clr, 32'hf);
		apb(1, a_irq_en, 0);
		meas(120, 0);
		repeat (2) @(posedge clk_sys_in);
		chk("irq masked", 0, irq);
		apb(0, a_irq_stat, 0);
		chk("irq status", 1, q[i_done]);
		apb(1, a_ctrl, 32'h5);
		apb(1, a_lo1, -1000);
		chk("limit refused", 1, e);
		apb(0, a_lo1, 0);
		chk("refused kept", 100, q);
		apb(1, a_hi1, 999);
		chk("limit taken", 0, e);
		apb(0, a_hi1, 0);
		chk("limit kept", 999, q);
		apb(1, a_lo1, -50);
		apb(1, a_hi1, 50);
		apb(1, a_nominal, 1000);
		meas(1003, 0);
		chk("pct pass", 6'h02, {ou, ul, gp, sf});
		chk("buzzer off", 0, buz);
		meas(1000, 0);
		chk("pct zero", 6'h02, {ou, ul, gp, sf});
		meas(1100, 0);
		chk("pct over", 6'h20, {ou, ul, gp, sf});
		meas(940, 0);
		chk("pct under", 6'h10, {ou, ul, gp, sf});
		// Mid-run reset must clear outputs and settings
		@(posedge clk_sys_in);
		sys_rst_in <= 1;
		repeat (2) @(posedge clk_sys_in);
		sys_rst_in <= 0;
		chk("reset outputs", 0, {ou, ul, gp, sf, rvo, buz, irq});
		apb(0, a_ctrl, 0);
		chk("ctrl after reset", ctrl_rst, q);
		finish_test();
	end
endmodule

// [verilog/bin_sorter_pkg.sv]
// Package of constants and types for the resistance bin sorter
//
// Function
// - In percentage mode only limits between -99.9 and +99.9 percent are accepted.
// - A negative reading without over-range or open flag always sorts as below lower limit.
// - An over-range or open reading always sorts as above upper limit.
// - With one gear, only gear one limits are used.
// - With two gears, only gear one and gear two limits are used.
// - With two gears, above-upper needs the reading above both gear upper limits.
// - With two gears, below-lower needs the reading below both gear lower limits.
// - Five sorting outputs exist: upper fail, lower fail and three gear passes.
// - A reading inside the overall span but in no gear is a sort failure, not counted.
// - With counting on, above, pass and below counters saturate at 99999.
// - Percentage deviation is (reading - nominal) / nominal times one hundred.
// - The alarm setting makes the buzzer sound on pass, on fail, or never.
package bin_sorter_pkg;
	localparam int data_w = 32;
	localparam int addr_w = 8;
	localparam int cnt_w = 17;
	localparam logic [cnt_w-1:0] cnt_max = 17'h1869f;
	// Percent limits in tenths of a percent
	localparam logic signed [31:0] pct_limit = 32'sh000003e7;
	localparam logic signed [31:0] pct_scale = 32'sh000003e8;
	localparam int div_steps = 48;
	localparam logic [addr_w-1:0] a_ctrl = 8'h00;
	localparam logic [addr_w-1:0] a_nominal = 8'h04;
	localparam logic [addr_w-1:0] a_lo1 = 8'h08;
	localparam logic [addr_w-1:0] a_hi1 = 8'h0c;
	localparam logic [addr_w-1:0] a_lo2 = 8'h10;
	localparam logic [addr_w-1:0] a_hi2 = 8'h14;
	localparam logic [addr_w-1:0] a_lo3 = 8'h18;
	localparam logic [addr_w-1:0] a_hi3 = 8'h1c;
	localparam logic [addr_w-1:0] a_result = 8'h20;
	localparam logic [addr_w-1:0] a_cnt_hi = 8'h24;
	localparam logic [addr_w-1:0] a_cnt_pass = 8'h28;
	localparam logic [addr_w-1:0] a_cnt_lo = 8'h2c;
	localparam logic [addr_w-1:0] a_irq_stat = 8'h30;
	localparam logic [addr_w-1:0] a_irq_en = 8'h34;
	localparam logic [addr_w-1:0] a_irq_clr = 8'h38;
	localparam logic [addr_w-1:0] a_status = 8'h3c;
	// Control fields
	localparam int f_gears = 0;
	localparam int f_pct = 2;
	localparam int f_count = 3;
	localparam int f_alarm = 4;
	localparam int f_cnt_clr = 6;
	localparam logic [31:0] ctrl_rst = 32'h00000001;
	// Interrupt bits
	localparam int i_done = 0;
	localparam int i_fail = 1;
	localparam int i_sortfail = 2;
	localparam int i_limit_rej = 3;
	localparam int irq_w = 4;
	typedef enum logic [1:0] {
		alarm_off = 2'h0,
		alarm_pass = 2'h1,
		alarm_fail = 2'h2
	} alarm_mode_t;
	typedef enum logic [2:0] {
		res_pass1 = 3'h1,
		res_pass2 = 3'h2,
		res_pass3 = 3'h3,
		res_over = 3'h4,
		res_under = 3'h5,
		res_sortfail = 3'h6
	} result_t;
	typedef enum logic [2:0] {
		st_idle = 3'b001,
		st_div = 3'b010,
		st_judge = 3'b100
	} state_t;
endpackage

// [verilog/pct_divider.sv]
`timescale 1ns/1ps
// Restoring divider for the percentage deviation
module pct_divider
	import bin_sorter_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	input wire logic start_in,
	input wire logic signed [data_w-1:0] reading_in,
	input wire logic signed [data_w-1:0] nominal_in,
	output logic done_out,
	output logic signed [data_w-1:0] quot_out
);
	logic [47:0] rem;
	logic [47:0] quo;
	logic [47:0] dvs;
	logic neg;
	logic busy;
	logic [5:0] step;
	logic signed [48:0] diff_w;
	logic [47:0] num_abs;
	logic [47:0] den_abs;
	logic [47:0] rem_sh;
	logic [63:0] prod_w;
	// Deviation numerator scaled by 1000 for tenths of a percent
	assign diff_w = 49'(reading_in) - 49'(nominal_in);
	assign prod_w = 64'(diff_w[48] ? -diff_w : diff_w) * 64'(pct_scale);
	assign num_abs = prod_w[47:0];
	assign den_abs = 48'(nominal_in[data_w-1] ? -nominal_in : nominal_in);
	assign rem_sh = {rem[46:0], quo[47]};
	logic take;
	logic [47:0] next_quo;
	logic signed [31:0] sat_q;
	assign take = rem_sh >= dvs;
	assign next_quo = {quo[46:0], take};
	// Huge deviations saturate rather than wrap into a small value
	assign sat_q = (next_quo[47:31] != 17'h0) ? 32'sh7fffffff : 32'(next_quo[30:0]);

	always_ff @(posedge clk_sys_in) begin
		done_out <= 1'b0;
		if (sys_rst_in) begin
			busy <= 1'b0;
			step <= 6'h00;
			rem <= 48'h0;
			quo <= 48'h0;
			dvs <= 48'h0;
			neg <= 1'b0;
			quot_out <= 32'sh0;
		end else if (start_in) begin
			busy <= 1'b1;
			step <= 6'(div_steps);
			rem <= 48'h0;
			quo <= num_abs;
			dvs <= den_abs;
			neg <= diff_w[48] ^ nominal_in[data_w-1];
		end else if (busy) begin
			quo <= next_quo;
			rem <= take ? rem_sh - dvs : rem_sh;
			step <= step - 6'h01;
			if (step == 6'h01) begin
				busy <= 1'b0;
				done_out <= 1'b1;
				// Lands with done, so a zero quotient still replaces the old one
				quot_out <= neg ? -sat_q : sat_q;
			end
		end
	end
endmodule

// [verilog/resistance_bin_sorter.sv]
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
// Resistance bin sorter with APB registers, counters and alarm
module resistance_bin_sorter
	import bin_sorter_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [addr_w-1:0] paddr,
	input wire logic [data_w-1:0] pwdata,
	output logic [data_w-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic reading_valid_in,
	input wire logic signed [data_w-1:0] reading_in,
	input wire logic over_range_in,
	input wire logic open_circuit_in,
	output logic over_upper_result_out,
	output logic under_lower_result_out,
	output logic [2:0] gear_pass_out,
	output logic sort_fail_out,
	output logic result_valid_out,
	output logic buzzer_out,
	output logic irq_out
);
	logic [31:0] ctrl;
	logic signed [31:0] nominal_reference;
	logic signed [31:0] lo_lim [3];
	logic signed [31:0] hi_lim [3];
	logic [cnt_w-1:0] cnt_over;
	logic [cnt_w-1:0] cnt_pass;
	logic [cnt_w-1:0] cnt_under;
	logic [irq_w-1:0] irq_stat;
	logic [irq_w-1:0] irq_en;
	logic [2:0] last_result;
	state_t state;
	state_t next_state;
	logic signed [31:0] value;
	logic forced_over;
	logic forced_under;
	logic div_done;
	logic signed [31:0] div_q;

	wire wr = psel & penable & pwrite;
	wire rd = psel & penable & ~pwrite;
	wire [1:0] qualified_gear_count = ctrl[f_gears +: 2];
	wire judgement_display_mode = ctrl[f_pct];
	wire count_en = ctrl[f_count];
	wire [1:0] alarm_sel = ctrl[f_alarm +: 2];
	wire mapped = (paddr[1:0] == 2'h0) && (paddr <= a_status);
	wire [2:0] gear_act;
	wire [2:0] in_gear;
	wire [2:0] above_g;
	wire [2:0] below_g;
	wire limit_write = wr && mapped && paddr >= a_lo1 && paddr <= a_hi3;
	wire signed [31:0] wval = pwdata;
	wire pct_ok = (wval <= pct_limit) && (wval >= -pct_limit);
	wire limit_rej = limit_write && judgement_display_mode && !pct_ok;
	wire [1:0] lim_idx = 2'((paddr - a_lo1) >> 3);
	wire lim_is_hi = paddr[2];

	// One gear is always active; count 0 treated as 1
	assign gear_act[0] = 1'b1;
	assign gear_act[1] = qualified_gear_count >= 2'h2;
	assign gear_act[2] = qualified_gear_count == 2'h3;

	// Caller keeps each upper above its lower, else classes may overlap
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : gen_gear
			assign above_g[g] = !gear_act[g] || (value > hi_lim[g]);
			assign below_g[g] = !gear_act[g] || (value < lo_lim[g]);
			assign in_gear[g] = gear_act[g] && value >= lo_lim[g] && value <= hi_lim[g];
		end
	endgenerate

	wire all_above = &above_g;
	wire all_below = &below_g;
	result_t judge;
	always_comb begin
		if (forced_over) begin
			judge = res_over;
		end else if (forced_under) begin
			judge = res_under;
		end else if (all_above) begin
			judge = res_over;
		end else if (all_below) begin
			judge = res_under;
		end else if (in_gear[0]) begin
			judge = res_pass1;
		end else if (in_gear[1]) begin
			judge = res_pass2;
		end else if (in_gear[2]) begin
			judge = res_pass3;
		end else begin
			judge = res_sortfail;
		end
	end

	wire is_pass = judge == res_pass1 || judge == res_pass2 || judge == res_pass3;
	wire is_fail = judge == res_over || judge == res_under;
	wire judging = state == st_judge;
	wire need_div = judgement_display_mode && !over_range_in && !open_circuit_in
		&& reading_in >= 0 && nominal_reference != 32'sh0;

	pct_divider u_div (
		.clk_sys_in(clk_sys_in),
		.sys_rst_in(sys_rst_in),
		.start_in(state == st_idle && reading_valid_in && need_div),
		.reading_in(reading_in),
		.nominal_in(nominal_reference),
		.done_out(div_done),
		.quot_out(div_q)
	);

	always_comb begin
		next_state = state;
		case (state)
			st_idle: begin
				if (reading_valid_in) begin
					next_state = need_div ? st_div : st_judge;
				end
			end
			st_div: begin
				if (div_done) begin
					next_state = st_judge;
				end
			end
			st_judge: next_state = st_idle;
			default: next_state = st_idle;
		endcase
	end

	// Quotient lands with done; judge waits one extra cycle in st_div while value takes div_q
	logic div_wait;
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			state <= st_idle;
			div_wait <= 1'b0;
		end else if (state == st_div && div_done) begin
			div_wait <= 1'b1;
		end else if (div_wait) begin
			div_wait <= 1'b0;
			state <= st_judge;
		end else if (!(state == st_div && div_done)) begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			value <= 32'sh0;
			forced_over <= 1'b0;
			forced_under <= 1'b0;
		end else if (state == st_idle && reading_valid_in) begin
			value <= reading_in;
			forced_over <= over_range_in | open_circuit_in;
			forced_under <= reading_in < 0 && !over_range_in && !open_circuit_in;
		end else if (div_wait) begin
			value <= div_q;
		end
	end

	// Result outputs: five sorting lines plus failure and strobe
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			over_upper_result_out <= 1'b0;
			under_lower_result_out <= 1'b0;
			gear_pass_out <= 3'h0;
			sort_fail_out <= 1'b0;
			result_valid_out <= 1'b0;
			buzzer_out <= 1'b0;
			last_result <= 3'h0;
		end else begin
			result_valid_out <= judging;
			if (judging) begin
				over_upper_result_out <= judge == res_over;
				under_lower_result_out <= judge == res_under;
				gear_pass_out <= {judge == res_pass3, judge == res_pass2, judge == res_pass1};
				sort_fail_out <= judge == res_sortfail;
				last_result <= judge;
				buzzer_out <= (alarm_sel == alarm_pass && is_pass)
					|| (alarm_sel == alarm_fail && is_fail);
			end
		end
	end

	// Saturating counters; counting stops at the ceiling
	wire cnt_clr = wr && paddr == a_ctrl && pwdata[f_cnt_clr];
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in || cnt_clr) begin
			cnt_over <= '0;
			cnt_pass <= '0;
			cnt_under <= '0;
		end else if (judging && count_en) begin
			if (judge == res_over && cnt_over != cnt_max) begin
				cnt_over <= cnt_over + 1'b1;
			end
			if (is_pass && cnt_pass != cnt_max) begin
				cnt_pass <= cnt_pass + 1'b1;
			end
			if (judge == res_under && cnt_under != cnt_max) begin
				cnt_under <= cnt_under + 1'b1;
			end
		end
	end

	// Config registers; rejected percent limits leave the old value
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			ctrl <= ctrl_rst;
			nominal_reference <= 32'sh0;
			irq_en <= '0;
			for (int i = 0; i < 3; i++) begin
				lo_lim[i] <= 32'sh0;
				hi_lim[i] <= 32'sh0;
			end
		end else if (wr) begin
			if (paddr == a_ctrl) begin
				ctrl <= {26'h0, pwdata[5:0]};
			end
			if (paddr == a_nominal) begin
				nominal_reference <= pwdata;
			end
			if (paddr == a_irq_en) begin
				irq_en <= pwdata[irq_w-1:0];
			end
			if (limit_write && !limit_rej) begin
				if (lim_is_hi) begin
					hi_lim[lim_idx] <= wval;
				end else begin
					lo_lim[lim_idx] <= wval;
				end
			end
		end
	end

	// Set wins over a clear in the same cycle
	wire [irq_w-1:0] irq_set = {limit_rej, judging && judge == res_sortfail,
		judging && is_fail, judging};
	wire [irq_w-1:0] irq_clr = (wr && paddr == a_irq_clr) ? pwdata[irq_w-1:0] : '0;
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			irq_stat <= '0;
			irq_out <= 1'b0;
		end else begin
			irq_stat <= (irq_stat & ~irq_clr) | irq_set;
			irq_out <= |(((irq_stat & ~irq_clr) | irq_set) & irq_en);
		end
	end

	logic [31:0] rmux;
	always_comb begin
		case (paddr)
			a_ctrl: rmux = ctrl;
			a_nominal: rmux = nominal_reference;
			a_lo1: rmux = lo_lim[0];
			a_hi1: rmux = hi_lim[0];
			a_lo2: rmux = lo_lim[1];
			a_hi2: rmux = hi_lim[1];
			a_lo3: rmux = lo_lim[2];
			a_hi3: rmux = hi_lim[2];
			a_result: rmux = {29'h0, last_result};
			a_cnt_hi: rmux = {15'h0, cnt_over};
			a_cnt_pass: rmux = {15'h0, cnt_pass};
			a_cnt_lo: rmux = {15'h0, cnt_under};
			a_irq_stat: rmux = {28'h0, irq_stat};
			a_irq_en: rmux = {28'h0, irq_en};
			a_status: rmux = {29'h0, state};
			default: rmux = 32'h0;
		endcase
	end

	// Zero-wait APB slave; error on unmapped or rejected limit
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && (!mapped || (pwrite && judgement_display_mode
				&& paddr >= a_lo1 && paddr <= a_hi3 && !pct_ok));
			if (psel && !penable && !pwrite) begin
				prdata <= rmux;
			end
		end
	end
endmodule
